/* File: design/ebs_bus.sv */
/*
 * Multiplexed address/data bus sequencer with address strobe.
 * Assumes a core request port on clk_sys; pins resolved by the bench.
 */
`timescale 1ns/100ps
`default_nettype none
module ebs_bus
	import ebs_pkg::*;
(
	input wire logic clk_sys, // System clock, 10 MHz
	input wire logic nrst, // Synchronous reset, active low
	input wire logic strobe_sel, // Strap: 1 valid strobe, 0 latch strobe
	input wire logic dyn_width_en, // Width input honoured when high
	input wire logic req_valid, // Core requests a cycle
	output logic req_ready, // Request taken
	input wire logic req_ext, // Access targets external memory
	input wire logic req_write, // Write when high
	input wire logic req_word, // Core wants a 16-bit access
	input wire logic [ADDR_W-1:0] req_addr, // Byte address
	input wire logic [DATA_W-1:0] req_wdata, // Write data
	output logic rd_valid, // Read data available
	input wire logic rd_ready, // Core accepts read data
	output logic [DATA_W-1:0] rd_data, // Read data
	output logic in_ready, // Buffer room seen by bus logic
	input wire logic [DATA_W-1:0] shared_addr_data_lines_i, // Lines in
	output logic [DATA_W-1:0] shared_addr_data_lines_o, // Lines out
	output logic [DATA_W-1:0] shared_addr_data_lines_oe, // Line enables
	output logic strobe_o, // Shared strobe pin
	output logic upper_byte_enable_n, // High byte enable, low
	output logic rd_n, // Read strobe, low
	output logic wr_n, // Write strobe, low
	input wire logic cycle_width_select // Width pin, async
);
	ebs_state_e st_q, st_d;
	logic sel_q, sel_d, sel_done_q, sel_done_d;
	logic [2:0] ws_q;
	logic wsel_q, wsel_d;
	logic [DATA_W-1:0] ad_o_q, ad_o_d, ad_oe_q, ad_oe_d;
	logic str_q, str_d, ube_q, ube_d, rdn_q, rdn_d, wrn_q, wrn_d;
	logic w16_q, w16_d, wr_q, wr_d, a0_q, a0_d;
	logic [DATA_W-1:0] wdat_q, wdat_d;
	logic push, bvalid, bready;
	logic [DATA_W-1:0] bdata, pdata;
	logic idle_strobe;

	function automatic logic [DATA_W-1:0] lane_en(input logic w16,
		input logic a0, input logic ube_n);
		if (!w16) begin
			lane_en = 16'h00FF;
		end else begin
			lane_en = {{BYTE_W{!ube_n}}, {BYTE_W{!a0}}};
		end
	endfunction : lane_en

	ebs_buf2 u_buf (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.in_valid(push),
		.in_ready(bready),
		.in_data(pdata),
		.out_valid(bvalid),
		.out_ready(rd_ready),
		.out_data(bdata)
	);

	// Read path: an 8-bit cycle on odd address returns the byte in low lane
	assign pdata = (!w16_q && a0_q) ? {8'h00, shared_addr_data_lines_i[7:0]}
		: shared_addr_data_lines_i;
	assign push = (st_q == EBS_DATA) && !wr_q;
	assign idle_strobe = (sel_q == STROBE_SEL_ADV) ? 1'b1 : 1'b0;
	assign req_ready = (st_q == EBS_IDLE) && sel_done_q && bready;

	always_comb begin
		st_d = st_q;
		sel_d = sel_q;
		sel_done_d = 1'b1;
		ad_o_d = ad_o_q;
		ad_oe_d = 16'h0000;
		str_d = str_q;
		ube_d = ube_q;
		rdn_d = 1'b1;
		wrn_d = 1'b1;
		w16_d = w16_q;
		wr_d = wr_q;
		a0_d = a0_q;
		wdat_d = wdat_q;
		// Width pin change counts only once the last two stages agree
		wsel_d = (ws_q[2] == ws_q[1]) ? ws_q[2] : wsel_q;
		if (!sel_done_q) begin
			sel_d = strobe_sel;
			str_d = (strobe_sel == STROBE_SEL_ADV) ? 1'b1 : 1'b0;
		end
		unique case (st_q)
			EBS_IDLE: begin
				if (req_valid && req_ready && req_ext) begin
					st_d = EBS_ADDR;
					ad_o_d = req_addr;
					ad_oe_d = 16'hFFFF;
					str_d = (sel_q == STROBE_SEL_ADV) ? 1'b0 : 1'b1;
					ube_d = !(req_word || req_addr[ADDR_LSB]);
					wr_d = req_write;
					a0_d = req_addr[ADDR_LSB];
					wdat_d = req_word ? req_wdata
						: (req_addr[0] ? {req_wdata[7:0], req_wdata[7:0]}
						: req_wdata);
					w16_d = dyn_width_en ? wsel_q : 1'b1;
				end
			end
			EBS_ADDR: begin
				st_d = EBS_DATA;
				if (sel_q == STROBE_SEL_ALE) begin
					str_d = 1'b0;
				end
				if (dyn_width_en) begin
					w16_d = wsel_q;
				end
				if (!w16_d) begin
					ube_d = 1'b1;
				end
				ad_oe_d = wr_q ? lane_en(w16_d, a0_q, ube_d) : 16'h0000;
				ad_o_d = (!w16_d && a0_q) ? {8'h00, wdat_q[15:8]} : wdat_q;
				rdn_d = wr_q;
				wrn_d = !wr_q;
			end
			EBS_DATA: begin
				st_d = EBS_DONE;
				if (sel_q == STROBE_SEL_ADV) begin
					str_d = 1'b1;
				end
			end
			EBS_DONE: begin
				st_d = EBS_IDLE;
				ube_d = 1'b1;
			end
		endcase
		if (st_q == EBS_ADDR && wr_q) begin
			ad_oe_d = lane_en(w16_d, a0_q, ube_d);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			st_q <= EBS_IDLE;
			sel_q <= STROBE_SEL_ALE;
			sel_done_q <= 1'b0;
			ws_q <= 3'h0;
			wsel_q <= 1'b0;
			ad_o_q <= ADDR_RST;
			ad_oe_q <= 16'h0000;
			str_q <= 1'b0;
			ube_q <= 1'b1;
			rdn_q <= 1'b1;
			wrn_q <= 1'b1;
			w16_q <= 1'b1;
			wr_q <= 1'b0;
			a0_q <= 1'b0;
			wdat_q <= DATA_RST;
		end else begin
			st_q <= st_d;
			sel_q <= sel_d;
			sel_done_q <= sel_done_d;
			ws_q <= {ws_q[1:0], cycle_width_select};
			wsel_q <= wsel_d;
			ad_o_q <= ad_o_d;
			ad_oe_q <= ad_oe_d;
			str_q <= str_d;
			ube_q <= ube_d;
			rdn_q <= rdn_d;
			wrn_q <= wrn_d;
			w16_q <= w16_d;
			wr_q <= wr_d;
			a0_q <= a0_d;
			wdat_q <= wdat_d;
		end
	end

	assign shared_addr_data_lines_o = ad_o_q;
	assign shared_addr_data_lines_oe = ad_oe_q;
	assign strobe_o = str_q;
	assign upper_byte_enable_n = ube_q;
	assign rd_n = rdn_q;
	assign wr_n = wrn_q;
	assign rd_valid = bvalid;
	assign rd_data = bdata;
	assign in_ready = bready;

	sequence s_adv_cycle;
		(st_q == EBS_ADDR) ##1 (st_q == EBS_DATA) ##1 (st_q == EBS_DONE);
	endsequence

	chk_addr_phase_drive: assert property (@(posedge clk_sys) disable iff (!nrst)
		(st_q == EBS_ADDR) |-> (ad_oe_q == 16'hFFFF))
		else $error("address phase not fully driven");
	chk_adv_low_cycle: assert property (@(posedge clk_sys) disable iff (!nrst)
		(sel_q == STROBE_SEL_ADV && st_q == EBS_ADDR)
		|-> !strobe_o ##1 !strobe_o ##1 strobe_o)
		else $error("valid strobe timing wrong");
	chk_adv_idle_high: assert property (@(posedge clk_sys) disable iff (!nrst)
		(sel_done_q && sel_q == STROBE_SEL_ADV && st_q == EBS_IDLE)
		|-> strobe_o == idle_strobe)
		else $error("valid strobe low outside external cycle");
	chk_ale_start_pulse: assert property (@(posedge clk_sys) disable iff (!nrst)
		$rose(strobe_o) && sel_q == STROBE_SEL_ALE |-> s_adv_cycle)
		else $error("latch strobe outside cycle start");
	chk_ale_only_ext: assert property (@(posedge clk_sys) disable iff (!nrst)
		(req_valid && req_ready && !req_ext && sel_q == STROBE_SEL_ALE)
		|=> !strobe_o)
		else $error("latch strobe on internal access");
	chk_byte_select: assert property (@(posedge clk_sys) disable iff (!nrst)
		(st_q == EBS_DATA && !w16_q) |-> upper_byte_enable_n)
		else $error("upper enable in byte cycle");
	chk_width_pick: assert property (@(posedge clk_sys) disable iff (!nrst)
		(st_q == EBS_ADDR && dyn_width_en) |=> (w16_q == $past(wsel_q)))
		else $error("width select not followed");
	chk_strobe_fixed: assert property (@(posedge clk_sys) disable iff (!nrst)
		sel_done_q |=> $stable(sel_q))
		else $error("strobe choice changed");
endmodule : ebs_bus
`default_nettype wire

/* File: inc/ebs_pkg.sv */
/*
 * Constants for the external bus address/strobe block.
 * Assumes one 10 MHz system clock and a synchronous active-low reset.
 */
package ebs_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int BYTE_W = 8;
	localparam int ADDR_LSB = 0;
	localparam int ADDR_MSB = 15;
	localparam int BUF_DEPTH = 2;
	localparam int CLK_PERIOD_NS = 100;
	localparam int SYNC_STAGES = 3;
	localparam logic STROBE_SEL_ALE = 1'b0;
	localparam logic STROBE_SEL_ADV = 1'b1;
	localparam logic [1:0] DATA_PHASE_CYCLES = 2'h1;
	localparam logic [15:0] ADDR_RST = 16'h0000;
	localparam logic [15:0] DATA_RST = 16'h0000;

	typedef enum logic [1:0] {
		EBS_IDLE = 2'b00,
		EBS_ADDR = 2'b01,
		EBS_DATA = 2'b10,
		EBS_DONE = 2'b11
	} ebs_state_e;
endpackage : ebs_pkg

/* File: design/ebs_buf2.sv */
/*
 * Two-entry valid/ready buffer for read data returned from the bus.
 * Assumes both sides run on clk_sys.
 */
`timescale 1ns/100ps
`default_nettype none
module ebs_buf2
	import ebs_pkg::*;
(
	input wire logic clk_sys, // System clock
	input wire logic nrst, // Synchronous reset, active low
	input wire logic in_valid, // Word offered
	output logic in_ready, // Room for a word
	input wire logic [DATA_W-1:0] in_data, // Word in
	output logic out_valid, // Word available
	input wire logic out_ready, // Receiver takes word
	output logic [DATA_W-1:0] out_data // Word out
);
	logic [DATA_W-1:0] mem_q [BUF_DEPTH];
	logic [DATA_W-1:0] mem_d [BUF_DEPTH];
	logic rd_q, rd_d, wr_q, wr_d;
	logic [1:0] cnt_q, cnt_d;
	logic push, pop;

	assign in_ready = (cnt_q != 2'h2);
	assign out_valid = (cnt_q != 2'h0);
	assign out_data = mem_q[rd_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		mem_d = mem_q;
		if (push) begin
			mem_d[wr_q] = in_data;
		end
		wr_d = push ? ~wr_q : wr_q;
		rd_d = pop ? ~rd_q : rd_q;
		cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			cnt_q <= 2'h0;
			rd_q <= 1'b0;
			wr_q <= 1'b0;
			mem_q[0] <= DATA_RST;
			mem_q[1] <= DATA_RST;
		end else begin
			cnt_q <= cnt_d;
			rd_q <= rd_d;
			wr_q <= wr_d;
			mem_q <= mem_d;
		end
	end
endmodule : ebs_buf2
`default_nettype wire

/* File: verif/ebs_mem_mdl.sv */
/* External memory behind an address latch.
   Assumes the ebs_bus pins, sampled on clk_sys. */
`timescale 1ns/100ps
`default_nettype none
module ebs_mem_mdl
	import ebs_pkg::*;
(
	input wire logic clk_sys, // Clock
	input wire logic sel, // Strap seen by device
	input wire logic wide, // 16-bit bus
	input wire logic stb, // Strobe pin
	input wire logic ube_n, // Upper enable
	input wire logic rd_n, // Read strobe
	input wire logic wr_n, // Write strobe
	input wire logic [DATA_W-1:0] lo, // Device drive
	input wire logic [DATA_W-1:0] oe, // Device enables
	output logic [DATA_W-1:0] li // Wire level
);
	logic [7:0] mem [logic [15:0]];
	logic [15:0] lat_q = 16'h0000;
	logic [15:0] drv_q = 16'h0000;
	function automatic logic [7:0] rb(input logic [15:0] a);
		return mem.exists(a) ? mem[a] : 8'hEE;
	endfunction : rb
	assign li = (oe & lo) | (~oe & drv_q);
	always @(posedge clk_sys) begin
		if ((sel ? !stb : stb) && rd_n && wr_n && &oe) begin
			lat_q <= lo;
		end
		if (!wr_n && !wide) begin
			mem[lat_q] = li[7:0];
		end
		if (!wr_n && wide && !lat_q[0]) begin
			mem[lat_q] = li[7:0];
		end
		if (!wr_n && wide && !ube_n) begin
			mem[lat_q | 16'h0001] = li[15:8];
		end
	end
	// Lines not driven flip every cycle instead of holding
	always @(negedge clk_sys) begin
		if (!rd_n && wide) begin
			drv_q <= {rb(lat_q | 16'h0001), rb(lat_q & 16'hFFFE)};
		end else if (!rd_n) begin
			drv_q <= {~drv_q[15:8], rb(lat_q)};
		end else begin
			drv_q <= ~drv_q;
		end
	end
endmodule : ebs_mem_mdl
`default_nettype wire

/* File: verif/external_bus_address_strobes_tb_top.sv */
/* Self-checking bench for ebs_bus with a memory model.
   Assumes inputs change on the falling edge of clk_sys. */
`timescale 1ns/100ps
`default_nettype none
module external_bus_address_strobes_tb_top
	import ebs_pkg::*;
;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic sel = 1'b1;
	logic req_valid = 1'b0;
	logic req_ext = 1'b0;
	logic req_write = 1'b0;
	logic req_word = 1'b0;
	logic [15:0] req_addr = 16'h0000;
	logic [15:0] req_wdata = 16'h0000;
	logic rd_ready = 1'b0;
	logic wsel = 1'b1;
	logic rnd_on = 1'b0;
	wire logic req_ready, rd_valid, in_ready, stb, ube_n, rd_n, wr_n;
	wire logic [DATA_W-1:0] rd_data, li, lo, oe;
	logic [15:0] exp_q[$];
	logic [15:0] msk_q[$];
	logic [7:0] sh [logic [15:0]];
	logic [15:0] ad [6];
	int fails = 0;
	int cmp_count = 0;
	always #50 clk_sys = ~clk_sys;
	ebs_bus dut (.clk_sys(clk_sys), .nrst(nrst), .strobe_sel(sel),
		.dyn_width_en(1'b1), .req_valid(req_valid), .req_ready(req_ready),
		.req_ext(req_ext), .req_write(req_write), .req_word(req_word),
		.req_addr(req_addr), .req_wdata(req_wdata), .rd_valid(rd_valid),
		.rd_ready(rd_ready), .rd_data(rd_data), .in_ready(in_ready),
		.shared_addr_data_lines_i(li), .shared_addr_data_lines_o(lo),
		.shared_addr_data_lines_oe(oe), .strobe_o(stb),
		.upper_byte_enable_n(ube_n), .rd_n(rd_n), .wr_n(wr_n),
		.cycle_width_select(wsel));
	ebs_mem_mdl mdl (.clk_sys(clk_sys), .sel(sel), .wide(wsel), .stb(stb),
		.ube_n(ube_n), .rd_n(rd_n), .wr_n(wr_n), .lo(lo), .oe(oe), .li(li));
	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : stop_test
	task automatic chk(input string nm, input logic [15:0] e, g, m);
		cmp_count++;
		if ((g & m) !== (e & m)) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, e & m, g & m);
		end
	endtask : chk
	task automatic do_req(input logic e, w, wd, input logic [15:0] a, d);
		int n = 0;
		req_ext = e;
		req_write = w;
		req_word = wd;
		req_addr = a;
		req_wdata = d;
		req_valid = 1'b1;
		while (req_ready !== 1'b1 && n < 100) begin
			@(negedge clk_sys);
			n++;
		end
		if (n >= 100) begin
			fails++;
			stop_test();
		end
		@(negedge clk_sys);
		req_valid = 1'b0;
		repeat (3) begin
			if (!e) chk("int_oe", 16'h0000, oe, 16'hFFFF);
			if (!e) chk("int_strobe", {15'h0, sel}, {15'h0, stb}, 16'h1);
			@(negedge clk_sys);
		end
	endtask : do_req
	task automatic wr(input logic wd, input logic [15:0] a, d);
		do_req(1'b1, 1'b1, wd, a, d);
		if (!wsel || !a[0]) sh[a] = d[7:0];
		if (wsel && (wd || a[0])) sh[a | 16'h0001] = d[15:8];
	endtask : wr
	task automatic rd(input logic wd, input logic [15:0] a);
		exp_q.push_back(wsel ? {sh[a | 16'h0001], sh[a]} : {8'h00, sh[a]});
		msk_q.push_back(wsel ? 16'hFFFF : 16'h00FF);
		do_req(1'b1, 1'b0, wd, a, 16'h0000);
	endtask : rd
	task automatic drain();
		for (int n = 0; n < 60 && exp_q.size() > 0; n++) @(negedge clk_sys);
	endtask : drain
	always @(negedge clk_sys) rd_ready <= rnd_on ? 1'($urandom) : 1'b0;
	always @(posedge clk_sys) begin
		if (rd_valid === 1'b1 && rd_ready === 1'b1 && exp_q.size() == 0) begin
			chk("rd_extra", 16'h0000, 16'hFFFF, 16'hFFFF);
		end else if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
			chk("rd_data", exp_q.pop_front(), rd_data, msk_q.pop_front());
		end
	end
	initial begin
		#2000000;
		fails++;
		stop_test();
	end
	initial begin
		logic [7:0] b;
		logic [15:0] a;
		void'($urandom(84));
		for (int m = 1; m >= 0; m--) begin
			sel = m[0];
			wsel = 1'b1;
			rnd_on = 1'b1;
			nrst = 1'b0;
			repeat (4) @(negedge clk_sys);
			nrst = 1'b1;
			repeat (5) @(negedge clk_sys);
			do_req(1'b0, 1'b0, 1'b1, 16'($urandom), 16'h0000);
			for (int i = 0; i < 6; i++) begin
				ad[i] = 16'($urandom) & 16'hFFFE;
				wr(1'b1, ad[i], 16'($urandom));
				b = 8'($urandom);
				wr(1'b0, ad[i] | 16'(i & 1), {b, b});
			end
			for (int i = 0; i < 6; i++) rd(1'b1, ad[i]);
			wsel = 1'b0;
			repeat (5) @(negedge clk_sys);
			for (int i = 0; i < 6; i++) begin
				a = 16'($urandom);
				b = 8'($urandom);
				wr(1'b0, a, {b, b});
				rd(1'b0, a);
			end
			drain();
			rnd_on = 1'b0;
			@(negedge clk_sys);
			rd(1'b0, a);
			rd(1'b0, a);
			chk("req_ready_full", 16'h0, {15'h0, req_ready}, 16'h1);
			chk("in_ready_full", 16'h0, {15'h0, in_ready}, 16'h1);
			rnd_on = 1'b1;
			drain();
		end
		stop_test();
	end
endmodule : external_bus_address_strobes_tb_top
`default_nettype wire
